// >>> logic/mipc_defines.svh
// Purpose: map and issue control constants
// Assumes: one core clock, 8-bit in-flight tags
// Notes: penalties are in core clock cycles
// Overview of operation
// - map gives each instruction unique 8-bit tag
// - tag stays reserved from map until retire
// - mapped instruction written into its issue queue
// - integer queue: 20 entries, four issues/cycle
// - float queue: 15 entries, two issues/cycle
// - issued entry idles n+1, deleted n+2
// - register read takes file data or bypass
// - load reads tag+data, store tag only
// - store data held until store retires
// - integer operates write results in stage 6
// - penalty counted from cycle after trigger fetch
// - conditional branch mispredict costs 7 cycles
// - jump or privileged return mispredict costs 8
// - memory ordering trap costs 14 cycles
// - other memory replay traps cost 13 cycles
// - float arithmetic trap costs 13 plus latency
// - integer loads go to lower pipes only
// - float stores: store ports or lower pipes
// - integer conditional branches: upper pipes only
// - jumps, calls, returns: lower_pipe_a only
// - logical ops and compares: any integer pipe
// - multimedia misc class: upper_pipe_a only
// - either-cluster ops balanced per fetch block
`ifndef MIPC_DEFINES_SVH
`define MIPC_DEFINES_SVH
`define MIPC_TAG_W 8
`define MIPC_TAGS 256
`define MIPC_CNT_W 9
`define MIPC_MAP_W 4
`define MIPC_IQ_DEPTH 20
`define MIPC_IQ_ISSUE 4
`define MIPC_FQ_DEPTH 15
`define MIPC_FQ_ISSUE 2
`define MIPC_DATA_W 64
`define MIPC_REG_W 5
`define MIPC_NPIPE 8
`define MIPC_PIPE_W 3
`define MIPC_M_LA 8'h01
`define MIPC_M_LB 8'h02
`define MIPC_M_UA 8'h04
`define MIPC_M_UB 8'h08
`define MIPC_M_FSA 8'h10
`define MIPC_M_FSB 8'h20
`define MIPC_M_FA 8'h40
`define MIPC_M_FM 8'h80
`define MIPC_M_LOWER 8'h03
`define MIPC_M_UPPER 8'h0c
`define MIPC_PEN_W 6
`define MIPC_PEN_BRANCH 6'h07
`define MIPC_PEN_JUMP 6'h08
`define MIPC_PEN_ORDER 6'h0e
`define MIPC_PEN_REPLAY 6'h0d
`define MIPC_PEN_DTB 6'h0d
`define MIPC_PEN_ITB 6'h07
`define MIPC_PEN_IARITH 6'h0c
`define MIPC_PEN_FPBASE 6'h0d
`endif

// >>> logic/mipc_issue_queue.sv
// Purpose: issue queue with multi-issue select
// Assumes: caller never enqueues beyond free
// Notes: select scans slot order, not age order
`timescale 1ns/1ns
`include "mipc_defines.svh"
module mipc_issue_queue import mipc_pkg::*; #(
    parameter int DEPTH = `MIPC_IQ_DEPTH,
    parameter int WIDTH = `MIPC_IQ_ISSUE,
    parameter int FW = $clog2(DEPTH + 1)
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [`MIPC_MAP_W-1:0] enq_valid,
    input mipc_entry_t [`MIPC_MAP_W-1:0] enq,
    input wire logic flush,
    input mipc_tag_t flush_tag,
    input mipc_tag_t oldest_tag,
    input mipc_mask_t busy,
    output mipc_mask_t claim,
    output mipc_issue_t [WIDTH-1:0] issue,
    output logic [FW-1:0] free
);
    typedef struct packed {
        logic [DEPTH-1:0] valid;
        logic [DEPTH-1:0] held;
        mipc_entry_t [DEPTH-1:0] ent;
        mipc_issue_t [WIDTH-1:0] iss;
        logic [FW-1:0] free;
    } mipc_q_state_t;
    mipc_q_state_t st_r;
    mipc_q_state_t st_nxt;

    always_comb begin
        int n;
        logic placed;
        st_nxt = st_r;
        st_nxt.iss = '0;
        claim = '0;
        n = 0;
        placed = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (st_r.held[i]) begin
                st_nxt.valid[i] = 1'b0;
                st_nxt.held[i] = 1'b0;
            end
            if (flush && mipc_younger(st_r.ent[i].tag, flush_tag, oldest_tag)) begin
                st_nxt.valid[i] = 1'b0;
                st_nxt.held[i] = 1'b0;
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            placed = 1'b0;
            for (int p = 0; p < `MIPC_NPIPE; p++) begin
                if (st_nxt.valid[i] && n < WIDTH && !placed && st_r.ent[i].mask[p] && !busy[p] && !claim[p]) begin
                    placed = 1'b1;
                    claim[p] = 1'b1;
                    st_nxt.held[i] = 1'b1;
                    st_nxt.iss[n].valid = 1'b1;
                    st_nxt.iss[n].tag = st_r.ent[i].tag;
                    st_nxt.iss[n].cls = st_r.ent[i].cls;
                    st_nxt.iss[n].pipe = p[`MIPC_PIPE_W-1:0];
                    st_nxt.iss[n].src = st_r.ent[i].src;
                    n = n + 1;
                end
            end
        end
        for (int k = 0; k < `MIPC_MAP_W; k++) begin
            placed = 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                if (enq_valid[k] && !placed && !st_nxt.valid[i]) begin
                    placed = 1'b1;
                    st_nxt.valid[i] = 1'b1;
                    st_nxt.held[i] = 1'b0;
                    st_nxt.ent[i] = enq[k];
                end
            end
        end
        st_nxt.free = '0;
        for (int i = 0; i < DEPTH; i++) begin
            st_nxt.free = st_nxt.free + FW'(!st_nxt.valid[i]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
            st_r.free <= FW'(DEPTH);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign issue = st_r.iss;
    assign free = st_r.free;
endmodule

// >>> logic/mipc_map_issue.sv
// Purpose: map, issue, register read, execute and data-cache stage control
// Assumes: one retire per cycle in tag order; abort_in marks the trigger fetch cycle
// Notes: execute carries operands only, no arithmetic
`timescale 1ns/1ns
`include "mipc_defines.svh"
module mipc_map_issue import mipc_pkg::*; #(
    parameter int IQ_DEPTH = `MIPC_IQ_DEPTH,
    parameter int IQ_ISSUE = `MIPC_IQ_ISSUE,
    parameter int FQ_DEPTH = `MIPC_FQ_DEPTH,
    parameter int FQ_ISSUE = `MIPC_FQ_ISSUE
) (
    input wire logic clock,
    input wire logic reset,
    input mipc_map_t [`MIPC_MAP_W-1:0] map_in,
    output logic map_ready,
    output logic [`MIPC_MAP_W-1:0] map_done,
    output mipc_tag_t [`MIPC_MAP_W-1:0] map_tag,
    output logic [`MIPC_CNT_W-1:0] in_flight,
    input wire logic retire_valid,
    output logic store_release,
    output mipc_tag_t store_release_tag,
    input mipc_abort_t abort_in,
    output logic fetch_hold,
    output logic fetch_resume,
    output logic [IQ_ISSUE-1:0][`MIPC_REG_W-1:0] rf_addr,
    input wire logic [IQ_ISSUE-1:0][`MIPC_DATA_W-1:0] rf_data,
    input mipc_bypass_t bypass,
    output mipc_stage_t [IQ_ISSUE-1:0] dc_stage,
    output logic [IQ_ISSUE-1:0] dc_tag_en,
    output logic [IQ_ISSUE-1:0] dc_data_en,
    output logic [IQ_ISSUE-1:0] sq_write,
    output logic [IQ_ISSUE-1:0] wb_en,
    output mipc_issue_t [FQ_ISSUE-1:0] fp_issue
);
    localparam int IFW = $clog2(IQ_DEPTH + 1);
    localparam int FFW = $clog2(FQ_DEPTH + 1);

    typedef struct packed {
        mipc_tag_t head;
        mipc_tag_t tail;
        logic [`MIPC_CNT_W-1:0] count;
        logic [`MIPC_PEN_W-1:0] pen;
        logic hold;
        logic resume;
        logic ready;
        logic [`MIPC_MAP_W-1:0] done;
        mipc_tag_t [`MIPC_MAP_W-1:0] tags;
        logic [`MIPC_TAGS-1:0] pend;
        logic rel;
        mipc_tag_t rel_tag;
        mipc_stage_t [IQ_ISSUE-1:0] s5;
        mipc_stage_t [IQ_ISSUE-1:0] s6;
        logic [IQ_ISSUE-1:0] dct;
        logic [IQ_ISSUE-1:0] dcd;
        logic [IQ_ISSUE-1:0] sqw;
        logic [IQ_ISSUE-1:0] wb;
    } mipc_top_state_t;

    mipc_top_state_t st_r;
    mipc_top_state_t st_nxt;

    mipc_entry_t [`MIPC_MAP_W-1:0] ent;
    logic [`MIPC_MAP_W-1:0] iq_v;
    logic [`MIPC_MAP_W-1:0] fq_v;
    mipc_issue_t [IQ_ISSUE-1:0] iq_iss;
    mipc_mask_t iq_claim;
    logic [IFW-1:0] iq_free;
    logic [FFW-1:0] fq_free;

    function automatic mipc_mask_t class_mask(input mipc_class_t c);
        case (c)
            C_ILD: class_mask = `MIPC_M_LOWER;
            C_FLD: class_mask = `MIPC_M_LOWER;
            C_IST: class_mask = `MIPC_M_LOWER;
            C_FST: class_mask = `MIPC_M_LOWER | `MIPC_M_FSA | `MIPC_M_FSB;
            C_IBR: class_mask = `MIPC_M_UPPER;
            C_ISHF: class_mask = `MIPC_M_UPPER;
            C_JSR: class_mask = `MIPC_M_LA;
            C_IOP: class_mask = `MIPC_M_LOWER | `MIPC_M_UPPER;
            C_IMISC: class_mask = `MIPC_M_UA;
            C_IMUL: class_mask = `MIPC_M_UB;
            C_FOP: class_mask = `MIPC_M_FA;
            C_FBR: class_mask = `MIPC_M_FA;
            C_FMUL: class_mask = `MIPC_M_FM;
            default: class_mask = '0;
        endcase
    endfunction

    function automatic logic lower_only(input mipc_class_t c);
        case (c)
            C_ILD: lower_only = 1'b1;
            C_FLD: lower_only = 1'b1;
            C_IST: lower_only = 1'b1;
            C_JSR: lower_only = 1'b1;
            default: lower_only = 1'b0;
        endcase
    endfunction

    function automatic logic upper_only(input mipc_class_t c);
        case (c)
            C_IBR: upper_only = 1'b1;
            C_ISHF: upper_only = 1'b1;
            C_IMISC: upper_only = 1'b1;
            C_IMUL: upper_only = 1'b1;
            default: upper_only = 1'b0;
        endcase
    endfunction

    // float stores, operates and branches live in the float queue
    function automatic logic float_queue(input mipc_class_t c);
        case (c)
            C_FST: float_queue = 1'b1;
            C_FOP: float_queue = 1'b1;
            C_FMUL: float_queue = 1'b1;
            C_FBR: float_queue = 1'b1;
            default: float_queue = 1'b0;
        endcase
    endfunction

    function automatic logic is_store(input mipc_class_t c);
        is_store = (c == C_IST) || (c == C_FST);
    endfunction

    function automatic logic is_load(input mipc_class_t c);
        is_load = (c == C_ILD) || (c == C_FLD);
    endfunction

    function automatic logic int_result(input mipc_class_t c);
        case (c)
            C_IOP: int_result = 1'b1;
            C_ISHF: int_result = 1'b1;
            C_IMISC: int_result = 1'b1;
            default: int_result = 1'b0;
        endcase
    endfunction

    function automatic logic [`MIPC_PEN_W-1:0] penalty(input mipc_abort_t a);
        case (a.kind)
            K_BRANCH: penalty = `MIPC_PEN_BRANCH;
            K_JUMP: penalty = `MIPC_PEN_JUMP;
            K_ORDER: penalty = `MIPC_PEN_ORDER;
            K_REPLAY: penalty = `MIPC_PEN_REPLAY;
            K_DTB: penalty = `MIPC_PEN_DTB;
            K_ITB: penalty = `MIPC_PEN_ITB;
            K_IARITH: penalty = `MIPC_PEN_IARITH;
            K_FPARITH: penalty = `MIPC_PEN_FPBASE + {2'h0, a.fp_lat};
            default: penalty = `MIPC_PEN_BRANCH;
        endcase
    endfunction

    always_comb begin
        logic fire;
        logic ret;
        logic kill4;
        logic kill5;
        logic [2:0] nl;
        logic [2:0] nu;
        logic [2:0] nmap;
        int need;
        mipc_tag_t t;
        mipc_class_t c;
        st_nxt = st_r;
        fire = 1'b0;
        ret = 1'b0;
        kill4 = 1'b0;
        kill5 = 1'b0;
        nl = '0;
        nu = '0;
        nmap = '0;
        need = 0;
        t = st_r.head;
        c = C_NOP;
        iq_v = '0;
        fq_v = '0;
        ent = '0;

        // retire first so a freed tag can be handed out again next cycle
        st_nxt.rel = 1'b0;
        if (retire_valid && st_r.count != '0) begin
            ret = 1'b1;
            st_nxt.tail = st_r.tail + 8'h01;
            st_nxt.rel = st_r.pend[st_r.tail];
            st_nxt.rel_tag = st_r.tail;
            st_nxt.pend[st_r.tail] = 1'b0;
        end

        for (int k = 0; k < `MIPC_MAP_W; k++) begin
            if (map_in[k].valid && st_r.ready && !abort_in.valid) begin
                fire = 1'b1;
            end
            if (map_in[k].valid && lower_only(map_in[k].cls)) begin
                nl = nl + 3'h1;
            end
            if (map_in[k].valid && upper_only(map_in[k].cls)) begin
                nu = nu + 3'h1;
            end
        end

        st_nxt.done = '0;
        for (int k = 0; k < `MIPC_MAP_W; k++) begin
            c = map_in[k].cls;
            ent[k].tag = t;
            ent[k].cls = c;
            ent[k].src = map_in[k].src;
            ent[k].mask = class_mask(c);
            if (c == C_IOP && map_in[k].valid) begin
                // either-cluster op joins the less loaded pair
                if (nl <= nu) begin
                    ent[k].mask = `MIPC_M_LOWER;
                    nl = nl + 3'h1;
                end else begin
                    ent[k].mask = `MIPC_M_UPPER;
                    nu = nu + 3'h1;
                end
            end
            if (fire && map_in[k].valid) begin
                st_nxt.done[k] = 1'b1;
                st_nxt.tags[k] = t;
                st_nxt.pend[t] = is_store(c);
                if (float_queue(c)) begin
                    fq_v[k] = 1'b1;
                end else if (c != C_NOP) begin
                    iq_v[k] = 1'b1;
                end
                t = t + 8'h01;
                nmap = nmap + 3'h1;
            end
        end
        st_nxt.head = t;
        st_nxt.count = st_r.count + `MIPC_CNT_W'(nmap) - `MIPC_CNT_W'(ret);

        if (abort_in.valid) begin
            // younger tags go back to the pool; the trigger stays in flight
            st_nxt.head = abort_in.tag + 8'h01;
            st_nxt.count = {1'b0, abort_in.tag - st_nxt.tail} + `MIPC_CNT_W'(1);
            st_nxt.pen = penalty(abort_in) - `MIPC_PEN_W'(1);
        end else if (st_r.pen != '0) begin
            st_nxt.pen = st_r.pen - `MIPC_PEN_W'(1);
        end
        st_nxt.resume = !abort_in.valid && st_r.pen == `MIPC_PEN_W'(1);
        st_nxt.hold = st_nxt.pen != '0;

        // queue free counts lag one cycle, so a firing map reserves a second block
        need = fire ? 2 * `MIPC_MAP_W : `MIPC_MAP_W;
        st_nxt.ready = !st_nxt.hold
            && int'(st_nxt.count) <= `MIPC_TAGS - `MIPC_MAP_W
            && int'(iq_free) >= need
            && int'(fq_free) >= need;

        for (int s = 0; s < IQ_ISSUE; s++) begin
            kill4 = abort_in.valid && mipc_younger(iq_iss[s].tag, abort_in.tag, st_r.tail);
            kill5 = abort_in.valid && mipc_younger(st_r.s5[s].tag, abort_in.tag, st_r.tail);
            st_nxt.s5[s].valid = iq_iss[s].valid && !kill4;
            st_nxt.s5[s].tag = iq_iss[s].tag;
            st_nxt.s5[s].cls = iq_iss[s].cls;
            st_nxt.s5[s].pipe = iq_iss[s].pipe;
            if (bypass.valid && bypass.rnum == iq_iss[s].src) begin
                st_nxt.s5[s].data = bypass.data;
            end else begin
                st_nxt.s5[s].data = rf_data[s];
            end
            st_nxt.s6[s] = st_r.s5[s];
            st_nxt.s6[s].valid = st_r.s5[s].valid && !kill5;
            c = st_r.s5[s].cls;
            st_nxt.dct[s] = st_nxt.s6[s].valid && (is_load(c) || is_store(c));
            st_nxt.dcd[s] = st_nxt.s6[s].valid && is_load(c);
            st_nxt.sqw[s] = st_nxt.s6[s].valid && is_store(c);
            st_nxt.wb[s] = st_nxt.s6[s].valid && int_result(c);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    mipc_issue_queue #(
        .DEPTH(IQ_DEPTH),
        .WIDTH(IQ_ISSUE),
        .FW(IFW)
    ) u_int_q (
        .clock(clock),
        .reset(reset),
        .enq_valid(iq_v),
        .enq(ent),
        .flush(abort_in.valid),
        .flush_tag(abort_in.tag),
        .oldest_tag(st_r.tail),
        .busy('0),
        .claim(iq_claim),
        .issue(iq_iss),
        .free(iq_free)
    );

    // float stores get a lower pipe only if integer left it idle
    mipc_issue_queue #(
        .DEPTH(FQ_DEPTH),
        .WIDTH(FQ_ISSUE),
        .FW(FFW)
    ) u_float_q (
        .clock(clock),
        .reset(reset),
        .enq_valid(fq_v),
        .enq(ent),
        .flush(abort_in.valid),
        .flush_tag(abort_in.tag),
        .oldest_tag(st_r.tail),
        .busy(iq_claim),
        .claim(),
        .issue(fp_issue),
        .free(fq_free)
    );

    always_comb begin
        for (int s = 0; s < IQ_ISSUE; s++) begin
            rf_addr[s] = iq_iss[s].src;
        end
    end

    assign map_ready = st_r.ready;
    assign map_done = st_r.done;
    assign map_tag = st_r.tags;
    assign in_flight = st_r.count;
    assign store_release = st_r.rel;
    assign store_release_tag = st_r.rel_tag;
    assign fetch_hold = st_r.hold;
    assign fetch_resume = st_r.resume;
    assign dc_stage = st_r.s6;
    assign dc_tag_en = st_r.dct;
    assign dc_data_en = st_r.dcd;
    assign sq_write = st_r.sqw;
    assign wb_en = st_r.wb;
endmodule

// >>> logic/mipc_pkg.sv
// Purpose: shared types of map and issue control
// Assumes: constants from mipc_defines.svh
// Notes: tag order is modulo 256 relative to the oldest tag
`include "mipc_defines.svh"
package mipc_pkg;
    typedef enum logic [3:0] {
        C_NOP, C_ILD, C_FLD, C_IST, C_FST, C_IBR, C_JSR, C_IOP,
        C_ISHF, C_IMISC, C_IMUL, C_FOP, C_FMUL, C_FBR
    } mipc_class_t;
    typedef enum logic [2:0] {
        K_BRANCH, K_JUMP, K_ORDER, K_REPLAY, K_DTB, K_ITB, K_IARITH, K_FPARITH
    } mipc_abort_kind_t;
    typedef logic [`MIPC_TAG_W-1:0] mipc_tag_t;
    typedef logic [`MIPC_NPIPE-1:0] mipc_mask_t;
    typedef struct packed {
        logic valid;
        mipc_class_t cls;
        logic [`MIPC_REG_W-1:0] src;
    } mipc_map_t;
    typedef struct packed {
        mipc_tag_t tag;
        mipc_class_t cls;
        mipc_mask_t mask;
        logic [`MIPC_REG_W-1:0] src;
    } mipc_entry_t;
    typedef struct packed {
        logic valid;
        mipc_tag_t tag;
        mipc_class_t cls;
        logic [`MIPC_PIPE_W-1:0] pipe;
        logic [`MIPC_REG_W-1:0] src;
    } mipc_issue_t;
    typedef struct packed {
        logic valid;
        mipc_abort_kind_t kind;
        mipc_tag_t tag;
        logic [3:0] fp_lat;
    } mipc_abort_t;
    typedef struct packed {
        logic valid;
        logic [`MIPC_REG_W-1:0] rnum;
        logic [`MIPC_DATA_W-1:0] data;
    } mipc_bypass_t;
    typedef struct packed {
        logic valid;
        mipc_tag_t tag;
        mipc_class_t cls;
        logic [`MIPC_PIPE_W-1:0] pipe;
        logic [`MIPC_DATA_W-1:0] data;
    } mipc_stage_t;
    function automatic logic mipc_younger(mipc_tag_t t, mipc_tag_t ref_t, mipc_tag_t old);
        mipc_tag_t a;
        mipc_tag_t b;
        a = t - old;
        b = ref_t - old;
        return a > b;
    endfunction
endpackage

// >>> testbench/mipc_far_side.sv
// Purpose: register file beyond register read
// Assumes: contents fixed per register
// Notes: same-cycle answer; distinct values expose bad addresses
`timescale 1ns/1ns
`include "mipc_defines.svh"
module mipc_far_side import mipc_pkg::*; #(
    parameter int IQ_ISSUE = `MIPC_IQ_ISSUE
) (
    input logic [IQ_ISSUE-1:0][`MIPC_REG_W-1:0] rf_addr,
    output logic [IQ_ISSUE-1:0][`MIPC_DATA_W-1:0] rf_data
);
    always_comb begin
        for (int s = 0; s < IQ_ISSUE; s++) begin
            rf_data[s] = {59'h0c3a5f1e2d4b697, rf_addr[s]};
        end
    end
endmodule

// >>> testbench/mipc_map_issue_properties.sv
// Purpose: port checks of map and issue
// Assumes: no abort while a penalty counts
// Notes: pipe legality judged in stage 6
`timescale 1ns/1ns
`include "mipc_defines.svh"
module mipc_map_issue_properties import mipc_pkg::*; #(
    parameter int IQ_ISSUE = `MIPC_IQ_ISSUE
) (
    input logic clock,
    input logic reset,
    input mipc_map_t [`MIPC_MAP_W-1:0] map_in,
    input logic map_ready,
    input logic [`MIPC_MAP_W-1:0] map_done,
    input mipc_tag_t [`MIPC_MAP_W-1:0] map_tag,
    input logic [`MIPC_CNT_W-1:0] in_flight,
    input logic retire_valid,
    input logic store_release,
    input mipc_abort_t abort_in,
    input logic fetch_hold,
    input logic fetch_resume,
    input mipc_stage_t [IQ_ISSUE-1:0] dc_stage,
    input logic [IQ_ISSUE-1:0] dc_tag_en,
    input logic [IQ_ISSUE-1:0] dc_data_en,
    input logic [IQ_ISSUE-1:0] sq_write,
    input logic [IQ_ISSUE-1:0] wb_en
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    logic [3:0] vmask;
    logic take;
    assign vmask = {map_in[3].valid, map_in[2].valid, map_in[1].valid, map_in[0].valid};
    assign take = map_ready && !abort_in.valid && (vmask != 4'h0);
    function automatic logic pipe_ok(mipc_class_t c, logic [2:0] p);
        case (c)
            C_ILD, C_FLD, C_IST: return p < 3'h2;
            C_IBR, C_ISHF: return p[2:1] == 2'h1;
            C_JSR: return p == 3'h0;
            C_IMISC: return p == 3'h2;
            C_IMUL: return p == 3'h3;
            C_IOP: return p < 3'h4;
            default: return 1'b0;
        endcase
    endfunction
    a_tag_order: assert property (map_done[0] && map_done[1] |-> map_tag[1] == map_tag[0] + 8'h01)
        else $error("tags not sequential");
    a_map_answer: assert property (take |=> map_done == $past(vmask))
        else $error("lanes not answered");
    a_retire_count: assert property (retire_valid && in_flight != 0 && !abort_in.valid && !take
        |=> in_flight == $past(in_flight) - 9'h001) else $error("retire lost");
    a_release_cause: assert property (store_release |-> $past(retire_valid) && $past(in_flight) != 0)
        else $error("release without retire");
    a_abort_branch: assert property (abort_in.valid && abort_in.kind == K_BRANCH
        |=> fetch_hold [*6] ##1 (fetch_resume && !fetch_hold)) else $error("branch penalty wrong");
    a_abort_jump: assert property (abort_in.valid && abort_in.kind == K_JUMP
        |=> fetch_hold [*7] ##1 fetch_resume) else $error("jump penalty wrong");
    a_abort_order: assert property (abort_in.valid && abort_in.kind == K_ORDER |-> ##14 fetch_resume)
        else $error("order penalty wrong");
    a_abort_replay: assert property (abort_in.valid && abort_in.kind == K_REPLAY |-> ##13 fetch_resume)
        else $error("replay penalty wrong");
    a_abort_blocks: assert property (abort_in.valid |=> !map_ready && map_done == 4'h0)
        else $error("map during abort");
    for (genvar s = 0; s < IQ_ISSUE; s++) begin : g_slot
        a_load_arrays: assert property (dc_data_en[s] |-> dc_tag_en[s] && dc_stage[s].valid
            && dc_stage[s].cls inside {C_ILD, C_FLD}) else $error("data access not by load");
        a_store_tagonly: assert property (dc_stage[s].valid && dc_stage[s].cls == C_IST
            |-> dc_tag_en[s] && !dc_data_en[s] && sq_write[s]) else $error("store access wrong");
        a_write_back: assert property (wb_en[s] == (dc_stage[s].valid
            && dc_stage[s].cls inside {C_IOP, C_ISHF, C_IMISC})) else $error("write-back wrong");
        a_pipe_class: assert property (dc_stage[s].valid |-> pipe_ok(dc_stage[s].cls, dc_stage[s].pipe))
            else $error("illegal pipe");
    end
    c_full_block: cover property (take && vmask == 4'hf);
    c_release: cover property (store_release);
    c_resume: cover property (fetch_resume);
endmodule
bind mipc_map_issue mipc_map_issue_properties #(.IQ_ISSUE(IQ_ISSUE)) u_props (.*);

// >>> testbench/mipc_map_issue_test.sv
// Purpose: self-checking bench of map and issue
// Assumes: far side supplies register data
// Notes: model predicts tags, counts, penalties, operands
`timescale 1ns/1ns
`include "mipc_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
$display("unexpected at %0t got %h expected %h", $time, g, e); end end
module mipc_map_issue_test import mipc_pkg::*; ;
    logic clock = 0;
    logic reset = 1;
    mipc_map_t [3:0] map_in = '0;
    logic retire_valid = 0;
    mipc_abort_t abort_in = '0;
    mipc_bypass_t bypass = '0;
    logic map_ready, fetch_hold, fetch_resume, store_release;
    logic [3:0] map_done, dc_tag_en, dc_data_en, sq_write, wb_en;
    mipc_tag_t [3:0] map_tag;
    mipc_tag_t store_release_tag;
    logic [8:0] in_flight;
    logic [3:0][4:0] rf_addr;
    logic [3:0][63:0] rf_data;
    mipc_stage_t [3:0] dc_stage;
    mipc_issue_t [1:0] fp_issue;
    int miscompares = 0;
    int checked = 0;
    int fl = 0, cnt = -1, cyc = 0, ab_cyc = -100;
    int pen[8] = '{7, 8, 14, 13, 13, 7, 12, 13};
    logic [7:0] nxt_t = 0, head = 0, exp_rel_t = 0;
    logic [3:0] exp_done = 0;
    logic exp_rel = 0;
    mipc_tag_t [3:0] exp_tag;
    mipc_class_t cls_of[256];
    logic [4:0] src_of[256];
    bit alive[256];
    int seen[256];
    logic [31:0] rnd = 91709;
    mipc_map_issue DUT (.*);
    mipc_far_side u_far (.*);
    initial forever #50 clock = ~clock;
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [63:0] rf_val(logic [4:0] r);
        return (bypass.valid && bypass.rnum == r) ? bypass.data : {59'h0c3a5f1e2d4b697, r};
    endfunction
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check();
        cyc++;
        if (cnt >= 0) cnt--;
        `CHK(map_done, exp_done)
        for (int k = 0; k < 4; k++) if (exp_done[k]) `CHK(map_tag[k], exp_tag[k])
        `CHK(in_flight, 9'(fl))
        `CHK(store_release, exp_rel)
        if (exp_rel) `CHK(store_release_tag, exp_rel_t)
        `CHK(fetch_resume, cnt == 0)
        `CHK(fetch_hold, cnt > 0)
        if (cnt > 0) `CHK(map_ready, 1'b0)
        for (int f = 0; f < 2; f++) if (fp_issue[f].valid && alive[fp_issue[f].tag])
            `CHK(fp_issue[f].cls, cls_of[fp_issue[f].tag])
        for (int s = 0; s < 4; s++) if (dc_stage[s].valid) begin
            if (alive[dc_stage[s].tag]) begin
                seen[dc_stage[s].tag]++;
                `CHK(dc_stage[s].cls, cls_of[dc_stage[s].tag])
                `CHK(dc_stage[s].data, rf_val(src_of[dc_stage[s].tag]))
                `CHK(seen[dc_stage[s].tag], 1)
            end else if (cyc > ab_cyc + 4) `CHK(dc_stage[s].valid, 1'b0)
        end
    endtask
    task automatic drive(input mipc_map_t [3:0] m, input logic rv, input mipc_abort_t ab);
        logic tk;
        @(negedge clock);
        check();
        map_in = m;
        retire_valid = rv;
        abort_in = ab;
        tk = map_ready && !ab.valid && (m[0].valid || m[1].valid || m[2].valid || m[3].valid);
        exp_rel = 0;
        exp_done = 0;
        if (rv && fl > 0) begin
            exp_rel = cls_of[head] inside {C_IST, C_FST};
            exp_rel_t = head;
            head++;
            fl--;
        end
        if (ab.valid) begin
            // trigger stays; younger tags go
            fl = int'(8'(ab.tag - head)) + 1;
            nxt_t = ab.tag + 8'h01;
            ab_cyc = cyc;
            for (int t = 0; t < 256; t++) if (8'(t - head) > 8'(ab.tag - head)) alive[t] = 0;
            cnt = pen[ab.kind] + (ab.kind == K_FPARITH ? int'(ab.fp_lat) : 0);
        end else if (tk) for (int k = 0; k < 4; k++) if (m[k].valid) begin
            exp_done[k] = 1;
            exp_tag[k] = nxt_t;
            cls_of[nxt_t] = m[k].cls;
            src_of[nxt_t] = m[k].src;
            alive[nxt_t] = 1;
            seen[nxt_t] = 0;
            nxt_t++;
            fl++;
        end
    endtask
    task automatic rand_blk(output mipc_map_t [3:0] m, input logic ld_only);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            m[k].valid = rnd[0] | rnd[1];
            m[k].cls = ld_only ? C_ILD : mipc_class_t'(4'(rnd[7:4] % 4'd14));
            m[k].src = rnd[12:8];
        end
    endtask
    initial begin
        mipc_map_t [3:0] m;
        mipc_abort_t ab;
        repeat (10) @(posedge clock);
        @(negedge clock) reset = 0;
        // pass 1 forwards r5: bypass beats the file
        for (int ph = 0; ph < 2; ph++) begin
            bypass = '{valid: ph[0], rnum: 5'h05, data: 64'h0123456789abcdef};
            repeat (80) begin
                rand_blk(m, 1'b0);
                drive(m, rnd[15], '0);
            end
            repeat (16) drive('0, 1'b0, '0);
        end
        // loads pile up so the flush meets queued entries
        for (int k = 0; k < 8; k++) begin
            repeat (3) begin
                rand_blk(m, 1'b1);
                drive(m, 1'b1, '0);
            end
            rnd = lfsr(rnd);
            ab = '{1'b1, mipc_abort_kind_t'(k), 8'(nxt_t - 8'h06), rnd[3:0]};
            drive('0, 1'b0, ab);
            repeat (32) drive('0, 1'b0, '0);
        end
        test_done();
    end
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
endmodule
